// ### rtl/drive_word_ctrl.sv
// drive command word decoder and status word assembler behind the
// holding register access port.
// assumes the protocol layer hands over one decoded request per cycle
// with its function code, and that all inputs are clk-synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "drive_ctrl_params.svh"

module drive_word_ctrl #(
  parameter int DATA_W    = 16,
  parameter int MAX_READS = `MAX_READ_REGS
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_hr_wr,
  input  wire logic                      i_hr_rd,
  input  wire logic [7:0]                i_hr_func,
  input  wire logic [15:0]               i_hr_addr,
  input  wire logic [7:0]                i_hr_count,
  input  wire logic [15:0]               i_hr_wdata,
  input  wire drive_ctrl_pkg::drive_cond_t i_cond,
  input  wire drive_ctrl_pkg::drive_cfg_t  i_cfg,
  input  wire logic                      i_link_lost,
  input  wire logic                      i_comm_fault,
  input  wire logic [15:0]               i_actual_value,
  output logic [15:0]                    o_hr_rdata,
  output logic                           o_hr_ack,
  output logic                           o_hr_err,
  output logic [15:0]                    o_cmd_word,
  output logic [15:0]                    o_bus_ref,
  output logic [15:0]                    o_status_word,
  output logic                           o_trip_clear,
  output drive_ctrl_pkg::drive_cmd_t     o_drive
);

  // ==========================================================
  // elaboration checks
  if (DATA_W != 16) begin : g_bad_width
    $error("drive_word_ctrl: word width must be 16");
  end
  if (MAX_READS < 1 || MAX_READS > 255) begin : g_bad_reads
    $error("drive_word_ctrl: read length limit out of range");
  end

  // ==========================================================
  // state
  drive_ctrl_pkg::drive_state_t s_r;
  drive_ctrl_pkg::drive_state_t s_nxt;
  drive_ctrl_pkg::drive_cmd_t   drv_c;
  logic [15:0]                  stw_c;
  logic [15:0]                  cw;
  logic                         hit_cmd;
  logic                         hit_ref;
  logic                         hit_stw;
  logic                         hit_act;
  logic                         wr_single;
  logic                         rd_ok;
  logic                         cmd_take;

  // address and function decode
  assign hit_cmd   = (i_hr_addr == `ADDR_CMD_WORD);
  assign hit_ref   = (i_hr_addr == `ADDR_BUS_REF);
  assign hit_stw   = (i_hr_addr == `ADDR_STATUS_WORD);
  assign hit_act   = (i_hr_addr == `ADDR_ACTUAL_VAL);
  assign wr_single = (i_hr_func == `FC_WRITE_SINGLE);
  // reads need function 03 and a length of 1..limit
  assign rd_ok     = (i_hr_func == `FC_READ_HOLDING)
                   && (i_hr_count != 8'h00)
                   && (i_hr_count <= 8'(MAX_READS));
  // a data-invalid word is acknowledged but never taken
  assign cmd_take  = i_hr_wr && wr_single && hit_cmd
                   && i_hr_wdata[`CB_DATA_VALID];

  // ==========================================================
  // command decode from the held command word
  assign cw = s_r.cw;
  always_comb begin
    drv_c            = '0;
    drv_c.preset_sel = {cw[`CB_PRESET_HI], cw[`CB_PRESET_LO]};
    drv_c.dc_brake   = ~cw[`CB_DC_BRAKE_N];
    drv_c.coast      = ~cw[`CB_COAST_N];
    drv_c.freeze     = ~cw[`CB_FREEZE_N];
    drv_c.freeze_up  = drv_c.freeze & i_cfg.di_speed_up;
    drv_c.freeze_dn  = drv_c.freeze & i_cfg.di_slow_down;
    // frozen output masks the ramped stops; coast/brake still act
    drv_c.quick_stop = ~cw[`CB_QSTOP_N] & ~drv_c.freeze;
    drv_c.ramp_stop  = ~cw[`CB_RAMPSTOP_N] & ~drv_c.freeze;
    // start needs every stop bit released
    drv_c.run_enable = cw[`CB_DC_BRAKE_N] & cw[`CB_COAST_N]
                     & cw[`CB_QSTOP_N] & cw[`CB_RAMPSTOP_N];
    drv_c.jog        = cw[`CB_JOG];
    drv_c.ramp2      = cw[`CB_RAMP_SEL];
    drv_c.relay1     = cw[`CB_RELAY1] & i_cfg.relay1_follow;
    drv_c.relay4     = cw[`CB_RELAY4] & i_cfg.relay4_follow;
    drv_c.setup_load = i_cfg.multi_setup;
    drv_c.setup_sel  = i_cfg.multi_setup
                     ? {cw[`CB_SETUP_HI], cw[`CB_SETUP_LO]}
                     : 2'b00;
    drv_c.reverse    = cw[`CB_REVERSE]
                     & (i_cfg.rev_src != drive_ctrl_pkg::REV_DIGITAL);
    // signed compare: negative references never count as over scale
    drv_c.ref_over_scale = $signed(s_r.bus_ref)
                         > $signed(`REF_FULL_SCALE);
  end

  // ==========================================================
  // status word assembly
  always_comb begin
    stw_c                 = '0;
    stw_c[`SB_CTRL_READY] = i_cond.ctrl_ready;
    stw_c[`SB_DRIVE_READY]= i_cond.drive_ready;
    stw_c[`SB_ENABLE]     = i_cond.enabled;
    stw_c[`SB_TRIP]       = i_cond.trip;
    stw_c[`SB_ERROR]      = i_cond.error;
    stw_c[`SB_UNUSED]     = 1'b0;
    stw_c[`SB_TRIPLOCK]   = i_cond.triplock;
    stw_c[`SB_WARNING]    = i_cond.warning;
    stw_c[`SB_ON_REF]     = i_cond.on_ref;
    stw_c[`SB_BUS_CTRL]   = i_cond.bus_ctrl_ok;
    stw_c[`SB_FREQ_OK]    = ~i_cond.at_low_limit
                          & ~i_cond.at_high_limit;
    stw_c[`SB_IN_OP]      = s_r.drv.run_enable
                          | i_cond.freq_nonzero;
    stw_c[`SB_AUTOSTART]  = i_cond.overtemp_hold;
    stw_c[`SB_VOLT]       = i_cond.dc_volt_bad;
    stw_c[`SB_TORQUE]     = i_cond.torque_limit;
    stw_c[`SB_TIMER]      = i_cond.thermal_over;
  end

  // ==========================================================
  // next state: register access and refresh
  always_comb begin
    s_nxt            = s_r;
    s_nxt.ack        = 1'b0;
    s_nxt.err        = 1'b0;
    s_nxt.trip_clear = 1'b0;
    s_nxt.drv        = drv_c;
    s_nxt.act_val    = i_actual_value;
    // link loss blanks the whole word, not only the fault bits
    s_nxt.drive_status_word        = (i_link_lost | i_comm_fault) ? 16'h0000
                                                    : stw_c;
    if (i_hr_wr) begin
      // write wins over a read presented in the same cycle
      s_nxt.ack = 1'b1;
      if (wr_single && hit_cmd) begin
        if (cmd_take) begin
          s_nxt.cw         = i_hr_wdata;
          // only a 0-to-1 step between taken words resets a trip
          s_nxt.trip_clear = i_hr_wdata[`CB_TRIP_RESET]
                           & ~s_r.cw[`CB_TRIP_RESET];
        end
      end else if (wr_single && hit_ref) begin
        s_nxt.bus_ref = i_hr_wdata;
      end else begin
        s_nxt.err = 1'b1;
      end
    end else if (i_hr_rd) begin
      s_nxt.ack   = 1'b1;
      s_nxt.rdata = 16'h0000;
      if (!rd_ok) begin
        s_nxt.err = 1'b1;
      end else if (hit_cmd) begin
        s_nxt.rdata = s_r.cw;
      end else if (hit_ref) begin
        s_nxt.rdata = s_r.bus_ref;
      end else if (hit_stw) begin
        s_nxt.rdata = s_r.drive_status_word;
      end else if (hit_act) begin
        s_nxt.rdata = s_r.act_val;
      end else begin
        s_nxt.err = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_r         <= '0;
      s_r.cw      <= `CMD_WORD_RST;
      s_r.bus_ref <= `BUS_REF_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign o_hr_rdata    = s_r.rdata;
  assign o_hr_ack      = s_r.ack;
  assign o_hr_err      = s_r.err;
  assign o_cmd_word    = s_r.cw;
  assign o_bus_ref     = s_r.bus_ref;
  assign o_status_word = s_r.drive_status_word;
  assign o_trip_clear  = s_r.trip_clear;
  assign o_drive       = s_r.drv;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_ignore_invalid;
    i_hr_wr && wr_single && hit_cmd && !i_hr_wdata[`CB_DATA_VALID]
      |=> $stable(s_r.cw) && !o_trip_clear;
  endproperty
  a_ignore_invalid: assert property (p_ignore_invalid)
    else $error("invalid command word was taken");

  property p_preset;
    cmd_take |-> ##2 o_drive.preset_sel == $past(i_hr_wdata[1:0], 2);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset select does not follow command");

  property p_trip_edge;
    o_trip_clear |-> s_r.cw[`CB_TRIP_RESET]
                  && !$past(s_r.cw[`CB_TRIP_RESET]);
  endproperty
  a_trip_edge: assert property (p_trip_edge)
    else $error("trip reset without rising edge");

  // freeze must come from the stored bit, and it masks the ramped stops
  property p_freeze_masks;
    o_drive.freeze |-> !$past(s_r.cw[`CB_FREEZE_N])
                    && !o_drive.quick_stop && !o_drive.ramp_stop;
  endproperty
  a_freeze_masks: assert property (p_freeze_masks)
    else $error("ramped stop active while frozen");

  property p_link_blank;
    (i_link_lost || i_comm_fault) |=> o_status_word == 16'h0000;
  endproperty
  a_link_blank: assert property (p_link_blank)
    else $error("status word not blanked on link loss");

  // decode lags the stored word by one cycle, so both are looked at late
  property p_reverse_src;
    o_drive.reverse |-> $past(i_cfg.rev_src) != drive_ctrl_pkg::REV_DIGITAL
                     && $past(s_r.cw[`CB_REVERSE]);
  endproperty
  a_reverse_src: assert property (p_reverse_src)
    else $error("reverse from digital source");

  property p_read_refuse;
    i_hr_rd && !i_hr_wr && !rd_ok |=> o_hr_ack && o_hr_err;
  endproperty
  a_read_refuse: assert property (p_read_refuse)
    else $error("bad read not refused");

  // back-to-back requests are legal, so only the answer cycle is judged
  property p_multi_refuse;
    i_hr_wr && i_hr_func == `FC_WRITE_MULTI
      |=> o_hr_ack && o_hr_err && $stable(o_cmd_word);
  endproperty
  a_multi_refuse: assert property (p_multi_refuse)
    else $error("multi write to one-register word accepted");

  property p_unused_bit;
    o_status_word[`SB_UNUSED] == 1'b0;
  endproperty
  a_unused_bit: assert property (p_unused_bit)
    else $error("unused status bit set");

  property p_coast_run;
    o_drive.coast || o_drive.dc_brake |-> !o_drive.run_enable
      && !($past(s_r.cw[`CB_COAST_N]) && $past(s_r.cw[`CB_DC_BRAKE_N]));
  endproperty
  a_coast_run: assert property (p_coast_run)
    else $error("run enabled while coasting or braking");

  // a single write to the reference always lands, whatever bit 10 says
  property p_ref_write;
    i_hr_wr && wr_single && hit_ref
      |=> o_hr_ack && !o_hr_err && o_bus_ref == $past(i_hr_wdata);
  endproperty
  a_ref_write: assert property (p_ref_write)
    else $error("bus reference write not stored");

  // every request gets exactly one answer one cycle later
  property p_ack_follows;
    o_hr_ack == $past(i_hr_wr || i_hr_rd);
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("register answer out of step with request");

  c_cmd_taken:  cover property (cmd_take ##2 o_drive.run_enable);
  c_trip_clear: cover property (o_trip_clear);
  c_read_stw:   cover property (i_hr_rd && hit_stw && rd_ok ##1 o_hr_ack);
  c_frozen:     cover property (o_drive.freeze && o_drive.freeze_up);
  c_reverse:    cover property (o_drive.reverse && o_drive.run_enable);

endmodule
`default_nettype wire

// ### shared/drive_ctrl_params.svh
// constants for the drive command/status word block: register addresses,
// bit positions, function codes and reset values.
// assumes it is included by bare name wherever these are needed.
`ifndef DRIVE_CTRL_PARAMS_SVH
`define DRIVE_CTRL_PARAMS_SVH

// ==========================================================
// holding register addresses (decimal 50000/50010/50200/50210)
`define ADDR_CMD_WORD     16'hC350
`define ADDR_BUS_REF      16'hC35A
`define ADDR_STATUS_WORD  16'hC418
`define ADDR_ACTUAL_VAL   16'hC422

// ==========================================================
// function codes
`define FC_READ_HOLDING   8'h03
`define FC_WRITE_SINGLE   8'h06
`define FC_WRITE_MULTI    8'h10

// ==========================================================
// command word bit positions
`define CB_PRESET_LO      0
`define CB_PRESET_HI      1
`define CB_DC_BRAKE_N     2
`define CB_COAST_N        3
`define CB_QSTOP_N        4
`define CB_FREEZE_N       5
`define CB_RAMPSTOP_N     6
`define CB_TRIP_RESET     7
`define CB_JOG            8
`define CB_RAMP_SEL       9
`define CB_DATA_VALID     10
`define CB_RELAY1         11
`define CB_RELAY4         12
`define CB_SETUP_LO       13
`define CB_SETUP_HI       14
`define CB_REVERSE        15

// ==========================================================
// status word bit positions
`define SB_CTRL_READY     0
`define SB_DRIVE_READY    1
`define SB_ENABLE         2
`define SB_TRIP           3
`define SB_ERROR          4
`define SB_UNUSED         5
`define SB_TRIPLOCK       6
`define SB_WARNING        7
`define SB_ON_REF         8
`define SB_BUS_CTRL       9
`define SB_FREQ_OK        10
`define SB_IN_OP          11
`define SB_AUTOSTART      12
`define SB_VOLT           13
`define SB_TORQUE         14
`define SB_TIMER          15

// ==========================================================
// reset values and scaling
`define CMD_WORD_RST      16'h0000
`define BUS_REF_RST       16'h0000
`define REF_FULL_SCALE    16'h4000
`define MAX_READ_REGS     10

`endif

// ### shared/drive_ctrl_pkg.sv
// types for the drive command/status word block.
// assumes drive_ctrl_params.svh holds the numeric constants.
package drive_ctrl_pkg;

  // ==========================================================
  // reversing source selection
  typedef enum logic [1:0] {
    REV_DIGITAL   = 2'b00,
    REV_SERIAL    = 2'b01,
    REV_LOGIC_OR  = 2'b10,
    REV_LOGIC_AND = 2'b11
  } rev_src_t;

  // decoded drive actions
  typedef struct packed {
    logic [1:0] preset_sel;
    logic       dc_brake;
    logic       coast;
    logic       quick_stop;
    logic       freeze;
    logic       freeze_up;
    logic       freeze_dn;
    logic       ramp_stop;
    logic       run_enable;
    logic       jog;
    logic       ramp2;
    logic       relay1;
    logic       relay4;
    logic [1:0] setup_sel;
    logic       setup_load;
    logic       reverse;
    logic       ref_over_scale;
  } drive_cmd_t;

  // conditions reported by the drive core
  typedef struct packed {
    logic ctrl_ready;
    logic drive_ready;
    logic enabled;
    logic trip;
    logic error;
    logic triplock;
    logic warning;
    logic on_ref;
    logic bus_ctrl_ok;
    logic at_low_limit;
    logic at_high_limit;
    logic freq_nonzero;
    logic overtemp_hold;
    logic dc_volt_bad;
    logic torque_limit;
    logic thermal_over;
  } drive_cond_t;

  // configuration and digital input state
  typedef struct packed {
    logic     relay1_follow;
    logic     relay4_follow;
    logic     multi_setup;
    rev_src_t rev_src;
    logic     di_speed_up;
    logic     di_slow_down;
  } drive_cfg_t;

  // whole block state
  typedef struct packed {
    logic [15:0] cw;
    logic [15:0] bus_ref;
    logic [15:0] act_val;
    logic [15:0] drive_status_word;
    logic [15:0] rdata;
    logic        ack;
    logic        err;
    logic        trip_clear;
    drive_cmd_t  drv;
  } drive_state_t;

endpackage

// ### test/hr_master_model.sv
// holding register master model: one read or write request per call.
// assumes the bench calls access() at a falling edge, answer next cycle.
`timescale 1ns/1ns
`default_nettype none
module hr_master_model (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic        i_err,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_func,
  output logic [15:0]      o_addr,
  output logic [7:0]       o_count,
  output logic [15:0]      o_wdata
);
  // ==========================================================
  // idle levels from time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_func = 8'h00;
    o_addr = 16'h0000;
    o_count = 8'h00;
    o_wdata = 16'h0000;
  end

  // ==========================================================
  // one-cycle request pulse; on release address and write data flip so
  // stale data is never mistaken for a held value
  task automatic access(input logic wr, input logic [7:0] fn,
      input logic [15:0] ad, input logic [7:0] n, input logic [15:0] wd,
      output logic ack, output logic err, output logic [15:0] rd);
    @(negedge i_clk);
    o_wr = wr;
    o_rd = !wr;
    o_func = fn;
    o_addr = ad;
    o_count = n;
    o_wdata = wd;
    @(negedge i_clk);
    ack = i_ack;
    err = i_err;
    rd = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~ad;
    o_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the drive command/status word block.
// assumes the master model drives the register port at falling edges.
`timescale 1ns/1ns
`default_nettype none
`include "drive_ctrl_params.svh"
module tb_top;
  logic                        clk = 1'b0;
  logic                        rst_n;
  logic                        wr, rd, ack, err, trip_clear;
  logic                        link_lost, comm_fault, a, er;
  logic [7:0]                  func, cnt;
  logic [15:0]                 addr, wdata, rdata, cmd_word, bus_ref;
  logic [15:0]                 drive_status_word, act, rdv;
  logic [15:0]                 held = 16'h0000;
  logic [15:0]                 bref = 16'h0000;
  drive_ctrl_pkg::drive_cond_t cond;
  drive_ctrl_pkg::drive_cfg_t  cfg;
  drive_ctrl_pkg::drive_cmd_t  drv, g;
  int                          n_mismatch = 0;
  int                          n_compared = 0;
  int                          cycles = 0;
  logic [15:0] cw_tab [26] = '{16'h047C, 16'h047D, 16'h047E, 16'h047F,
    16'h0478, 16'h0474, 16'h046C, 16'h045C, 16'h044C, 16'h043C, 16'h04FC,
    16'h04FC, 16'h047C, 16'h00FC, 16'h047C, 16'h04FC, 16'h057C, 16'h067C,
    16'h1C7C, 16'h1C7C, 16'h647C, 16'h647C, 16'h847C, 16'h847C, 16'h847C,
    16'h847C};
  // last entry: reverse bit with the digital source must be ignored
  logic [6:0] cf_tab [26] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
    7'h00, 7'h02, 7'h01, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
    7'h00, 7'h00, 7'h60, 7'h00, 7'h10, 7'h00, 7'h04, 7'h08, 7'h0C, 7'h00};
  logic [15:0] ref_tab [4] = '{16'h4000, 16'h4001, 16'hC000, 16'h7FFF};

  always #25 clk = ~clk;

  drive_word_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_hr_wr(wr),
    .i_hr_rd(rd), .i_hr_func(func), .i_hr_addr(addr), .i_hr_count(cnt),
    .i_hr_wdata(wdata), .i_cond(cond), .i_cfg(cfg),
    .i_link_lost(link_lost), .i_comm_fault(comm_fault),
    .i_actual_value(act), .o_hr_rdata(rdata), .o_hr_ack(ack),
    .o_hr_err(err), .o_cmd_word(cmd_word), .o_bus_ref(bus_ref),
    .o_status_word(drive_status_word), .o_trip_clear(trip_clear), .o_drive(drv));

  hr_master_model m (.i_clk(clk), .i_ack(ack), .i_err(err),
    .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_func(func), .o_addr(addr),
    .o_count(cnt), .o_wdata(wdata));

  // ==========================================================
  // expected decode and status, worked out from the bit meanings
  function automatic drive_ctrl_pkg::drive_cmd_t exp_drive(
      input logic [15:0] w, input drive_ctrl_pkg::drive_cfg_t c,
      input logic [15:0] r);
    drive_ctrl_pkg::drive_cmd_t d;
    d = '0;
    d.preset_sel = w[1:0];
    d.dc_brake = !w[2];
    d.coast = !w[3];
    d.quick_stop = !w[4] && w[5];
    d.freeze = !w[5];
    d.freeze_up = !w[5] && c.di_speed_up;
    d.freeze_dn = !w[5] && c.di_slow_down;
    d.ramp_stop = !w[6] && w[5];
    d.run_enable = w[2] && w[3] && w[4] && w[6];
    d.jog = w[8];
    d.ramp2 = w[9];
    d.relay1 = w[11] && c.relay1_follow;
    d.relay4 = w[12] && c.relay4_follow;
    d.setup_sel = c.multi_setup ? w[14:13] : 2'b00;
    d.setup_load = c.multi_setup;
    d.reverse = w[15] && (c.rev_src != drive_ctrl_pkg::REV_DIGITAL);
    d.ref_over_scale = $signed(r) > $signed(`REF_FULL_SCALE);
    return d;
  endfunction

  function automatic logic [15:0] exp_stw(input logic [15:0] c);
    logic run;
    run = held[2] && held[3] && held[4] && held[6];
    if (link_lost || comm_fault) return 16'h0000;
    return {c[0], c[1], c[2], c[3], c[4] || run, !c[6] && !c[5], c[7],
      c[8], c[9], c[10], 1'b0, c[11], c[12], c[13], c[14], c[15]};
  endfunction

  // ==========================================================
  // compare, register transfer and decode check helpers
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] fn,
      input logic [15:0] ad, input logic [7:0] n, input logic [15:0] wd,
      input logic e_err, input logic [15:0] e_rd);
    m.access(w, fn, ad, n, wd, a, er, rdv);
    chk("ack", 32'h0000_0001, {31'h0000_0000, a});
    chk("err", {31'h0000_0000, e_err}, {31'h0000_0000, er});
    if (!w) chk("rdata", {16'h0000, e_rd}, {16'h0000, rdv});
  endtask

  // decode lands one cycle after the stored word
  task automatic chk_drive;
    @(negedge clk);
    g = drv;
    chk("drive", 32'(exp_drive(held, cfg, bref)), 32'(g));
  endtask

  task automatic apply(input logic [15:0] w, input logic [6:0] cf);
    cfg = cf;
    xfer(1'b1, `FC_WRITE_SINGLE, `ADDR_CMD_WORD, 8'h01, w, 1'b0, 16'h0000);
    chk("trip", {31'h0, w[10] && w[7] && !held[7]}, {31'h0, trip_clear});
    if (w[10]) held = w;
    chk("cmd_word", {16'h0000, held}, {16'h0000, cmd_word});
    chk_drive();
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================
  // test sequence
  initial begin
    rst_n = 1'b0;
    link_lost = 1'b0;
    comm_fault = 1'b0;
    cond = '0;
    cfg = '0;
    act = 16'hC000;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk_drive();
    chk("cmd_rst", 32'h0000_0000, {16'h0000, cmd_word});
    $display("test reset done");
    for (int i = 0; i < 26; i++) apply(cw_tab[i], cf_tab[i]);
    $display("test command decode done");
    foreach (ref_tab[i]) begin
      xfer(1'b1, `FC_WRITE_SINGLE, `ADDR_BUS_REF, 8'h01, ref_tab[i], 1'b0, 16'h0000);
      bref = ref_tab[i];
      chk("bus_ref", {16'h0000, bref}, {16'h0000, bus_ref});
      chk_drive();
      xfer(1'b0, `FC_READ_HOLDING, `ADDR_BUS_REF, 8'h01, 16'h0000, 1'b0, bref);
    end
    xfer(1'b0, `FC_READ_HOLDING, `ADDR_ACTUAL_VAL, 8'h01, 16'h0000, 1'b0, act);
    $display("test reference done");
    xfer(1'b1, `FC_WRITE_MULTI, `ADDR_CMD_WORD, 8'h01, 16'h0400, 1'b1, 16'h0000);
    chk("cmd_kept", {16'h0000, held}, {16'h0000, cmd_word});
    xfer(1'b0, `FC_READ_HOLDING, `ADDR_CMD_WORD, 8'h01, 16'h0000, 1'b0,
      held);
    xfer(1'b1, `FC_WRITE_SINGLE, `ADDR_STATUS_WORD, 8'h01, 16'h0000, 1'b1, 16'h0000);
    xfer(1'b1, `FC_WRITE_SINGLE, `ADDR_ACTUAL_VAL, 8'h01, 16'h0000, 1'b1, 16'h0000);
    xfer(1'b1, `FC_WRITE_SINGLE, 16'hC351, 8'h01, 16'h0000, 1'b1, 16'h0000);
    xfer(1'b0, `FC_READ_HOLDING, `ADDR_STATUS_WORD, 8'h00, 16'h0000, 1'b1, 16'h0000);
    xfer(1'b0, `FC_READ_HOLDING, `ADDR_STATUS_WORD, 8'h0B, 16'h0000, 1'b1, 16'h0000);
    xfer(1'b0, `FC_WRITE_SINGLE, `ADDR_STATUS_WORD, 8'h01, 16'h0000, 1'b1, 16'h0000);
    xfer(1'b0, `FC_READ_HOLDING, 16'hC351, 8'h01, 16'h0000, 1'b1, 16'h0000);
    $display("test refusals done");
    apply(16'h0400, 7'h00);
    for (int i = 0; i < 19; i++) begin
      cond = (i < 16) ? 16'h0001 << i : 16'hFFFF;
      link_lost = (i == 17);
      comm_fault = (i == 18);
      repeat (2) @(negedge clk);
      chk("stw", {16'h0000, exp_stw(cond)}, {16'h0000, drive_status_word});
      xfer(1'b0, `FC_READ_HOLDING, `ADDR_STATUS_WORD, 8'h0A, 16'h0000, 1'b0, exp_stw(cond));
    end
    link_lost = 1'b0;
    comm_fault = 1'b0;
    cond = '0;
    apply(16'h047C, 7'h00);
    repeat (2) @(negedge clk);
    chk("stw_run", {16'h0000, exp_stw(cond)}, {16'h0000, drive_status_word});
    $display("test status done");
    finish_test();
  end
endmodule
`default_nettype wire
